// ==== verilog/cpubic_pkg.sv ====
// constants for the processor reset, interrupt and bus control block
package cpubic_pkg;
    // reset timing
    localparam int          RESET_HOLD_MIN_CLKS = 4;
    localparam int          RESET_SEQ_CLKS      = 7;
    localparam int          IRQ_EARLY_CLKS      = 9;
    localparam int          NMI_HIGH_MIN_CLKS   = 2;
    localparam int          CLK_PERIOD_NS       = 10;
    localparam int          POWERUP_US          = 50;
    localparam int          POWERUP_CLKS        = (POWERUP_US * 1000)
                                                  / CLK_PERIOD_NS;
    localparam logic [3:0]  SEQ_W_MAX           = 4'h7;
    localparam logic [3:0]  EARLY_MAX           = 4'h9;
    // addresses
    localparam logic [19:0] RESET_FETCH_ADDR    = 20'hffff0;
    localparam logic [19:0] VECTOR_TABLE_TOP    = 20'h003ff;
    localparam logic [7:0]  NMI_TYPE            = 8'h02;
    localparam int          VEC_ENTRY_SHIFT     = 2;
    // cycle status codes (max mode)
    localparam logic [2:0]  CS_IRQ_ACK_STROBE             = 3'h0;
    localparam logic [2:0]  CS_IO_RD            = 3'h1;
    localparam logic [2:0]  CS_IO_WR            = 3'h2;
    localparam logic [2:0]  CS_HALT             = 3'h3;
    localparam logic [2:0]  CS_FETCH            = 3'h4;
    localparam logic [2:0]  CS_MEM_RD           = 3'h5;
    localparam logic [2:0]  CS_MEM_WR           = 3'h6;
    localparam logic [2:0]  CS_PASSIVE          = 3'h7;
    // request kinds from the core
    localparam logic [1:0]  REQ_READ            = 2'h0;
    localparam logic [1:0]  REQ_WRITE           = 2'h1;
    localparam logic [1:0]  REQ_FETCH           = 2'h2;

    typedef enum logic [8:0] {
        BUS_IDLE = 9'h001,
        BUS_T1   = 9'h002,
        BUS_T2   = 9'h004,
        BUS_T3   = 9'h008,
        BUS_TW   = 9'h010,
        BUS_T4   = 9'h020,
        BUS_HALT = 9'h040,
        BUS_HOLD = 9'h080,
        BUS_RST  = 9'h100
    } cpubic_bus_state_type;

    typedef enum logic [4:0] {
        SEQ_NONE = 5'h01,
        SEQ_ACK1 = 5'h02,
        SEQ_ACK2 = 5'h04,
        SEQ_VEC  = 5'h08,
        SEQ_DONE = 5'h10
    } cpubic_seq_type;
endpackage

// ==== verilog/cpubic_top.sv ====
// reset, interrupt, halt, lock and bus cycle control of the processor
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - operations stop on reset rising and stay dormant; reset is synchronised
// - after reset falls, seven-clock sequence, then fetch from ffff0
// - maskable request within nine clocks of reset end may wait one instruction
// - three-state outputs float during reset; status shows passive one clock first
// - vector table spans 0 to 3ff, 256 entries of four bytes
// - nmi beats maskable request, rising-edge triggered, gives type 2
// - nmi edges latched and served at boundary; later edge retriggers
// - maskable request level sampled, honoured at boundary when enabled
// - every interrupt response clears enable; return restores it
// - two back-to-back acknowledge cycles; lock t3 to t2, off in t1 of second; no hold meanwhile
// - type byte read in second acknowledge, times four gives entry address
// - halt entry: late latch strobe in min mode, halt code in max mode
// - hold during halt keeps halt, reissues indication; irq or reset exits
// - lock asserted after prefix, released after next instruction; grants wait
// - wait repeats until test low; no bus cycles once queue full
// - bus request during wait floats drivers; interrupt serviced then wait refetched
// - strap high gives direct strobes, strap low gives coded status
// - read: strobe t1, select t1-t4, float bus and read strobe from t2
// - write: data from t2 into t4, write strobe t2 through t3 and waits
// - not ready inserts whole wait states between t3 and t4
module cpubic_top (
    // clock, reset, enable
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_clk_en,
    // pins from outside
    input  wire logic        i_config_strap,
    input  wire logic        i_nmi,
    input  wire logic        i_maskable_irq_in,
    input  wire logic        i_ready,
    input  wire logic        i_test_n,
    input  wire logic        i_hold_req,
    input  wire logic        i_request_grant_pin_in,
    input  wire logic [7:0]  i_addr_data_low,
    // core side
    input  wire logic        i_core_req,
    input  wire logic [1:0]  i_core_kind,
    input  wire logic        i_core_io,
    input  wire logic [19:0] i_core_addr,
    input  wire logic [7:0]  i_core_wdata,
    input  wire logic        i_core_boundary,
    input  wire logic        i_core_halt,
    input  wire logic        i_core_wait_instr,
    input  wire logic        i_core_queue_full,
    input  wire logic        i_core_lock_prefix,
    input  wire logic        i_core_lock_end,
    input  wire logic        i_core_if_set,
    input  wire logic        i_core_if_clr,
    input  wire logic        i_core_iret,
    input  wire logic        i_core_iret_if,
    // bus pins
    output logic [7:0]       o_addr_data_low,
    output logic             o_addr_data_low_oe,
    output logic [7:0]       o_addr_middle,
    output logic [3:0]       o_addr_high,
    output logic             o_addr_oe,
    output logic             o_addr_latch,
    output logic             o_io_mem_sel,
    output logic             o_xcvr_direction,
    output logic             o_xcvr_output_enable_n,
    output logic             o_status_zero_min,
    output logic             o_read_n,
    output logic             o_write_n,
    output logic             o_irq_ack_strobe_n,
    output logic             o_ctrl_oe,
    output logic [2:0]       o_cycle_status_code,
    output logic             o_status_oe,
    output logic             o_lock_n,
    output logic             o_hold_ack,
    output logic             o_request_grant_pin_out,
    output logic             o_request_grant_pin_oe,
    // core side results
    output logic             o_core_done,
    output logic [7:0]       o_core_rdata,
    output logic             o_core_busy,
    output logic             o_core_if,
    output logic             o_core_wait_release,
    output logic             o_vec_valid,
    output logic [19:0]      o_vec_fetch_addr,
    output logic [7:0]       o_vec_type,
    output logic [1:0]       o_vec_byte_idx,
    output logic             o_halted
);
    import cpubic_pkg::*;

    // three-flop input synchronisers
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sy1_ff;
    logic [NSYNC-1:0] sy2_ff;
    logic [NSYNC-1:0] sy3_ff;
    logic [NSYNC-1:0] pin_ff;
    assign pin_raw = {i_request_grant_pin_in, i_hold_req, i_test_n,
                      i_ready, i_maskable_irq_in, i_nmi};
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    sy1_ff[g] <= 1'b0;
                    sy2_ff[g] <= 1'b0;
                    sy3_ff[g] <= 1'b0;
                    pin_ff[g] <= 1'b0;
                end else if (i_clk_en) begin
                    sy1_ff[g] <= pin_raw[g];
                    sy2_ff[g] <= sy1_ff[g];
                    sy3_ff[g] <= sy2_ff[g];
                    // change counts once flops two and three agree
                    if (sy2_ff[g] == sy3_ff[g])
                        pin_ff[g] <= sy3_ff[g];
                end
            end
        end
    endgenerate
    logic s_nmi, s_irq, s_ready, s_test_n, s_hold, s_rqgt;
    assign s_nmi    = pin_ff[0];
    assign s_irq    = pin_ff[1];
    assign s_ready  = pin_ff[2];
    assign s_test_n = pin_ff[3];
    assign s_hold   = pin_ff[4];
    assign s_rqgt   = pin_ff[5];

    // strap caught after reset release
    logic [3:0] sq_cnt_ff;
    logic       min_mode_ff;
    always_ff @(posedge i_core_clk) begin
        if (i_clk_en && (i_rst || sq_cnt_ff != 4'h0))
            min_mode_ff <= i_config_strap;
    end

    // reset sequence counter; i_rst is synchronous so already synchronised
    logic       rst_first_ff;
    logic [3:0] early_cnt_ff;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sq_cnt_ff    <= SEQ_W_MAX;
            early_cnt_ff <= EARLY_MAX;
            rst_first_ff <= 1'b1;
        end else if (i_clk_en) begin
            rst_first_ff <= 1'b0;
            if (sq_cnt_ff != 4'h0)
                sq_cnt_ff <= sq_cnt_ff - 4'h1;
            if (early_cnt_ff != 4'h0)
                early_cnt_ff <= early_cnt_ff - 4'h1;
        end
    end
    logic running;
    assign running = (sq_cnt_ff == 4'h0);

    // nmi edge latch and interrupt enable
    logic nmi_prev_ff, nmi_pend_ff, if_ff, irq_defer_ff;
    logic take_nmi, take_irq, irq_start;
    cpubic_seq_type seq_ff;
    assign take_nmi  = running && i_core_boundary && nmi_pend_ff
                       && seq_ff == SEQ_NONE;
    // a fresh nmi edge not yet latched still beats the request
    assign take_irq  = running && i_core_boundary && !nmi_pend_ff
                       && !(s_nmi && !nmi_prev_ff)
                       && s_irq && if_ff && !irq_defer_ff
                       && seq_ff == SEQ_NONE;
    assign irq_start = take_nmi || take_irq;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            nmi_prev_ff  <= 1'b0;
            nmi_pend_ff  <= 1'b0;
            if_ff        <= 1'b0;
            irq_defer_ff <= 1'b0;
        end else if (i_clk_en) begin
            nmi_prev_ff <= s_nmi;
            // new edge wins over the clear of this service
            if (s_nmi && !nmi_prev_ff)
                nmi_pend_ff <= 1'b1;
            else if (take_nmi)
                nmi_pend_ff <= 1'b0;
            // early request may let one instruction run first
            if (s_irq && early_cnt_ff != 4'h0 && running)
                irq_defer_ff <= 1'b1;
            else if (i_core_boundary)
                irq_defer_ff <= 1'b0;
            if (irq_start)
                if_ff <= 1'b0;
            else if (i_core_iret)
                if_ff <= i_core_iret_if;
            else if (i_core_if_set)
                if_ff <= 1'b1;
            else if (i_core_if_clr)
                if_ff <= 1'b0;
        end
    end

    // bus cycle engine
    cpubic_bus_state_type st_ff;
    logic [1:0]  kind_ff;
    logic        io_ff, ack_ff, wr_ff;
    logic [19:0] addr_ff;
    logic [7:0]  wdata_ff, type_ff;
    logic [1:0]  vbyte_ff;
    logic        lock_ff, lock_pend_ff, halt_late_ff, halt_shown_ff;
    logic        wait_blk;
    logic        grant_pend_ff;
    logic        want_cycle;
    // wait holds the bus until test low once queue is full
    assign wait_blk   = i_core_wait_instr && s_test_n
                        && i_core_queue_full;
    // request still stands in the done cycle; never take it twice
    assign want_cycle = (seq_ff == SEQ_ACK1) || (seq_ff == SEQ_ACK2)
                        || (seq_ff == SEQ_VEC)
                        || (i_core_req && !wait_blk && seq_ff == SEQ_NONE
                            && !o_core_done);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_ff    <= BUS_RST;
            seq_ff   <= SEQ_NONE;
            kind_ff  <= REQ_FETCH;
            io_ff    <= 1'b0;
            ack_ff   <= 1'b0;
            wr_ff    <= 1'b0;
            addr_ff  <= RESET_FETCH_ADDR;
            wdata_ff <= 8'h00;
            type_ff  <= 8'h00;
            vbyte_ff <= 2'h0;
            halt_late_ff  <= 1'b0;
            halt_shown_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (irq_start) begin
                type_ff <= NMI_TYPE;
                // nmi needs no acknowledge cycles
                seq_ff  <= take_nmi ? SEQ_VEC : SEQ_ACK1;
                vbyte_ff <= 2'h0;
            end
            unique case (st_ff)
                BUS_RST: begin
                    if (running)
                        st_ff <= BUS_IDLE;
                end
                BUS_IDLE: begin
                    halt_late_ff <= 1'b0;
                    if (s_hold && seq_ff == SEQ_NONE && !lock_ff)
                        st_ff <= BUS_HOLD;
                    else if (want_cycle) begin
                        st_ff  <= BUS_T1;
                        ack_ff <= (seq_ff == SEQ_ACK1)
                                  || (seq_ff == SEQ_ACK2);
                        wr_ff  <= (seq_ff == SEQ_NONE)
                                  && i_core_kind == REQ_WRITE;
                        io_ff  <= (seq_ff == SEQ_NONE) && i_core_io;
                        kind_ff <= (seq_ff == SEQ_NONE) ? i_core_kind
                                                        : REQ_READ;
                        wdata_ff <= i_core_wdata;
                        // entry address is type times four
                        addr_ff <= (seq_ff == SEQ_VEC)
                            ? {10'h000, type_ff, vbyte_ff}
                            : i_core_addr;
                    end else if (i_core_halt && !halt_shown_ff) begin
                        st_ff <= BUS_HALT;
                        halt_late_ff <= 1'b1;
                    end
                end
                BUS_T1: st_ff <= BUS_T2;
                BUS_T2: st_ff <= BUS_T3;
                BUS_T3, BUS_TW: begin
                    st_ff <= s_ready ? BUS_T4 : BUS_TW;
                end
                BUS_T4: begin
                    st_ff <= BUS_IDLE;
                    unique case (seq_ff)
                        SEQ_ACK1: seq_ff <= SEQ_ACK2;
                        SEQ_ACK2: begin
                            type_ff <= i_addr_data_low;
                            seq_ff  <= SEQ_VEC;
                        end
                        SEQ_VEC: begin
                            vbyte_ff <= vbyte_ff + 2'h1;
                            if (vbyte_ff == 2'h3)
                                seq_ff <= SEQ_DONE;
                        end
                        SEQ_DONE, SEQ_NONE: ;
                    endcase
                end
                BUS_HALT: begin
                    halt_late_ff  <= 1'b0;
                    halt_shown_ff <= 1'b1;
                    if (irq_start || !i_core_halt)
                        st_ff <= BUS_IDLE;
                    else if (s_hold)
                        st_ff <= BUS_HOLD;
                end
                BUS_HOLD: begin
                    if (!s_hold) begin
                        st_ff <= BUS_IDLE;
                        halt_shown_ff <= 1'b0;
                    end
                end
                default: st_ff <= BUS_IDLE;
            endcase
            if (seq_ff == SEQ_DONE)
                seq_ff <= SEQ_NONE;
            if (!i_core_halt)
                halt_shown_ff <= 1'b0;
        end
    end

    // lock handling and request/grant recording
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            lock_ff       <= 1'b0;
            lock_pend_ff  <= 1'b0;
            grant_pend_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (i_core_lock_prefix)
                lock_pend_ff <= 1'b1;
            else if (lock_pend_ff && i_core_lock_end && st_ff == BUS_T4)
                lock_pend_ff <= 1'b0;
            if (s_rqgt && !grant_pend_ff)
                grant_pend_ff <= 1'b1;
            else if (!lock_ff && !lock_pend_ff)
                grant_pend_ff <= 1'b0;
            // acknowledge lock spans t3 of first to t2 of second, off in t1 of second
            lock_ff <= (lock_pend_ff && !(i_core_lock_end
                        && st_ff == BUS_T4))
                       || (seq_ff == SEQ_ACK1 && st_ff != BUS_IDLE
                           && st_ff != BUS_T1)
                       || (seq_ff == SEQ_ACK2 && st_ff == BUS_T1);
        end
    end

    // pin drivers, all registered
    logic nxt_drive;
    assign nxt_drive = (st_ff != BUS_RST) && (st_ff != BUS_HOLD)
                       && !i_rst;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_addr_data_low        <= 8'h00;
            o_addr_data_low_oe     <= 1'b0;
            o_addr_middle          <= 8'h00;
            o_addr_high            <= 4'h0;
            o_addr_oe              <= 1'b0;
            o_addr_latch           <= 1'b0;
            o_io_mem_sel           <= 1'b0;
            o_xcvr_direction       <= 1'b0;
            o_xcvr_output_enable_n <= 1'b1;
            o_status_zero_min      <= 1'b1;
            o_read_n               <= 1'b1;
            o_write_n              <= 1'b1;
            o_irq_ack_strobe_n     <= 1'b1;
            o_ctrl_oe              <= 1'b0;
            o_cycle_status_code    <= CS_PASSIVE;
            // passive for one clock, then float
            o_status_oe            <= rst_first_ff ? 1'b0 : 1'b1;
            o_lock_n               <= 1'b1;
            o_hold_ack             <= 1'b0;
            o_request_grant_pin_out <= 1'b0;
            o_request_grant_pin_oe <= 1'b0;
        end else if (i_clk_en) begin
            o_addr_oe   <= nxt_drive && !ack_ff;
            o_ctrl_oe   <= nxt_drive && min_mode_ff;
            o_status_oe <= nxt_drive && !min_mode_ff;
            o_addr_middle <= addr_ff[15:8];
            o_addr_high   <= addr_ff[19:16];
            o_addr_latch  <= (st_ff == BUS_T1) || halt_late_ff;
            o_io_mem_sel  <= (st_ff == BUS_HALT) ? 1'b1 : io_ff;
            o_xcvr_direction  <= (st_ff == BUS_HALT) ? 1'b1 : wr_ff;
            o_status_zero_min <= (st_ff == BUS_HALT) ? 1'b1
                                 : (kind_ff == REQ_FETCH);
            unique case (st_ff)
                BUS_T1: begin
                    o_addr_data_low    <= addr_ff[7:0];
                    o_addr_data_low_oe <= nxt_drive && !ack_ff;
                end
                // write data held one clock past the strobe
                BUS_T2, BUS_T3, BUS_TW, BUS_T4: begin
                    o_addr_data_low    <= wdata_ff;
                    o_addr_data_low_oe <= wr_ff;
                end
                default: begin
                    o_addr_data_low_oe <= 1'b0;
                end
            endcase
            o_read_n  <= !((st_ff == BUS_T2 || st_ff == BUS_T3
                          || st_ff == BUS_TW) && !wr_ff && !ack_ff);
            o_write_n <= !((st_ff == BUS_T2 || st_ff == BUS_T3
                          || st_ff == BUS_TW) && wr_ff);
            o_irq_ack_strobe_n <= !((st_ff == BUS_T2 || st_ff == BUS_T3
                          || st_ff == BUS_TW) && ack_ff);
            o_xcvr_output_enable_n <= !(st_ff == BUS_T2 || st_ff == BUS_T3
                                       || st_ff == BUS_TW);
            if (st_ff == BUS_HALT)
                o_cycle_status_code <= CS_HALT;
            else if (st_ff == BUS_IDLE && want_cycle)
                o_cycle_status_code <= (seq_ff == SEQ_ACK1
                                        || seq_ff == SEQ_ACK2) ? CS_IRQ_ACK_STROBE
                    : (seq_ff == SEQ_VEC) ? CS_MEM_RD
                    : (i_core_kind == REQ_FETCH) ? CS_FETCH
                    : (i_core_kind == REQ_WRITE)
                        ? (i_core_io ? CS_IO_WR : CS_MEM_WR)
                        : (i_core_io ? CS_IO_RD : CS_MEM_RD);
            else if (st_ff == BUS_T3 || st_ff == BUS_IDLE)
                o_cycle_status_code <= CS_PASSIVE;
            o_lock_n   <= !lock_ff;
            o_hold_ack <= (st_ff == BUS_HOLD);
            o_request_grant_pin_out <= 1'b0;
            o_request_grant_pin_oe  <= grant_pend_ff && !lock_ff
                                       && !lock_pend_ff;
        end
    end

    // core side results
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_core_done         <= 1'b0;
            o_core_rdata        <= 8'h00;
            o_core_busy         <= 1'b1;
            o_core_if           <= 1'b0;
            o_core_wait_release <= 1'b0;
            o_vec_valid         <= 1'b0;
            o_vec_fetch_addr    <= 20'h00000;
            o_vec_type          <= 8'h00;
            o_vec_byte_idx      <= 2'h0;
            o_halted            <= 1'b0;
        end else if (i_clk_en) begin
            o_core_done  <= (st_ff == BUS_T4) && seq_ff == SEQ_NONE;
            o_core_rdata <= i_addr_data_low;
            o_core_busy  <= !running || seq_ff != SEQ_NONE;
            o_core_if    <= if_ff;
            o_core_wait_release <= i_core_wait_instr && !s_test_n;
            o_vec_valid      <= (st_ff == BUS_T4) && seq_ff == SEQ_VEC;
            o_vec_fetch_addr <= addr_ff;
            o_vec_type       <= type_ff;
            o_vec_byte_idx   <= vbyte_ff;
            o_halted         <= (st_ff == BUS_HALT)
                                || (st_ff == BUS_HOLD && i_core_halt);
        end
    end
endmodule

`default_nettype wire

// ==== test/cpubic_asserts.sv ====
// concurrent checks on reset, strobes and vector addressing
`timescale 1ns/100ps
`default_nettype none
module cpubic_asserts import cpubic_pkg::*; (
    input wire logic        i_core_clk, i_rst, o_read_n, o_write_n,
    input wire logic        o_addr_latch, o_addr_oe, o_ctrl_oe, o_status_oe,
    input wire logic        o_core_done, o_vec_valid,
    input wire logic [2:0]  o_cycle_status_code,
    input wire logic [7:0]  o_vec_type,
    input wire logic [1:0]  o_vec_byte_idx,
    input wire logic [19:0] o_vec_fetch_addr
);
    default clocking cb @(posedge i_core_clk); endclocking
    AST_FLOAT: assert property (i_rst [*3] |-> !o_addr_oe && !o_ctrl_oe
        && !o_status_oe) else $error("drivers on in reset");
    AST_PASSIVE: assert property (i_rst [*2] |->
        o_cycle_status_code == CS_PASSIVE) else $error("status not idle");
    AST_DORMANT: assert property (i_rst [*3] |-> o_read_n && o_write_n
        && !o_core_done) else $error("activity in reset");
    AST_SEQ: assert property (disable iff (i_rst) $fell(i_rst) |->
        (o_read_n && !o_addr_latch) [*7]) else $error("bus during sequence");
    AST_EXCL: assert property (disable iff (i_rst)
        o_read_n || o_write_n) else $error("read and write together");
    AST_LATCH: assert property (disable iff (i_rst)
        o_addr_latch |=> !o_addr_latch) else $error("latch pulse too long");
    AST_RD_T2: assert property (disable iff (i_rst)
        $fell(o_read_n) |-> $past(o_addr_latch)) else $error("read not in t2");
    AST_VEC: assert property (disable iff (i_rst) o_vec_valid |->
        o_vec_fetch_addr == {10'h000, o_vec_type, o_vec_byte_idx})
        else $error("vector address wrong");
    AST_DONE: assert property (disable iff (i_rst)
        o_core_done |=> !o_core_done) else $error("done too long");
    cover property (disable iff (i_rst) o_vec_valid);
    cover property (disable iff (i_rst) $fell(o_write_n));
    cover property (disable iff (i_rst) $fell(o_read_n));
endmodule
bind cpubic_top cpubic_asserts chk (.*);
`default_nettype wire

// ==== test/cpubic_mem_model.sv ====
// memory and interrupt controller on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module cpubic_mem_model #(parameter logic [7:0] TYPE_BYTE = 8'h21) (
    input wire logic        i_clk, i_rd_n, i_wr_n, i_ack_n, i_latch, i_slow,
    input wire logic [19:0] i_addr,
    output logic [7:0]      o_data,
    output logic            o_ready
);
    logic [19:0] addr_ff;
    logic [7:0]  last_ff;
    logic [1:0]  wait_ff;
    always_ff @(posedge i_clk) begin
        if (i_latch) addr_ff <= i_addr;
        if (!i_rd_n || !i_ack_n) last_ff <= o_data;
        if (i_rd_n && i_wr_n && i_ack_n) wait_ff <= i_slow ? 2'h2 : 2'h0;
        else if (wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
    end
    assign o_ready = (wait_ff == 2'h0);
    // released bus shows inverted last byte so stale data cannot match
    assign o_data = !i_ack_n ? TYPE_BYTE :
        !i_rd_n ? addr_ff[7:0] ^ 8'h5a : ~last_ff;
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the bus control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cpubic_pkg::*;
    logic i_core_clk = 0, i_rst = 1, i_clk_en = 1, i_config_strap = 1;
    logic i_nmi = 0, i_maskable_irq_in = 0, i_ready, i_test_n = 1;
    logic i_hold_req = 0, i_request_grant_pin_in = 1, i_core_req = 0;
    logic i_core_io = 0, i_core_boundary = 0, i_core_halt = 0, slow = 0;
    logic i_core_wait_instr = 0, i_core_queue_full = 0, i_core_if_set = 0;
    logic i_core_lock_prefix = 0, i_core_lock_end = 0, i_core_if_clr = 0;
    logic i_core_iret = 0, i_core_iret_if = 0;
    logic [1:0] i_core_kind = 0, o_vec_byte_idx;
    logic [7:0] i_addr_data_low, i_core_wdata = 0, o_addr_data_low;
    logic [7:0] o_addr_middle, o_core_rdata, o_vec_type;
    logic [19:0] i_core_addr = 0, o_vec_fetch_addr;
    logic [3:0] o_addr_high;
    logic [2:0] o_cycle_status_code;
    logic o_addr_data_low_oe, o_addr_oe, o_addr_latch, o_io_mem_sel;
    logic o_xcvr_direction, o_xcvr_output_enable_n, o_status_zero_min;
    logic o_read_n, o_write_n, o_irq_ack_strobe_n, o_ctrl_oe, o_status_oe;
    logic o_lock_n, o_hold_ack, o_request_grant_pin_out, o_core_done;
    logic o_request_grant_pin_oe, o_core_busy, o_core_if, o_vec_valid;
    logic o_core_wait_release, o_halted;
    int n_errors = 0, n_compared = 0;
    cpubic_top dut (.*);
    cpubic_mem_model #(.TYPE_BYTE(8'h21)) mem (.i_clk(i_core_clk),
        .i_rd_n(o_read_n), .i_wr_n(o_write_n), .i_ack_n(o_irq_ack_strobe_n),
        .i_latch(o_addr_latch), .i_slow(slow), .o_data(i_addr_data_low),
        .i_addr({o_addr_high, o_addr_middle, o_addr_data_low}),
        .o_ready(i_ready));
    always #5 i_core_clk = ~i_core_clk;
    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until done; samples on falling edge to avoid races
    task automatic xfer(input logic [1:0] kind, input logic [19:0] a,
                        input logic [7:0] d, input logic [7:0] e);
        int k;
        @(posedge i_core_clk);
        i_core_req <= 1'b1; i_core_kind <= kind; i_core_addr <= a;
        i_core_wdata <= d;
        for (k = 0; k < 99 && o_core_done !== 1'b1; k++) begin
            @(negedge i_core_clk);
            if (o_write_n === 1'b0) check(o_addr_data_low, d);
        end
        if (kind != REQ_WRITE) check(o_core_rdata, e);
        @(posedge i_core_clk) i_core_req <= 1'b0;
        if (k == 99) begin n_errors++; final_report(); end
    endtask
    task automatic sc_reset_fetch;
        repeat (POWERUP_CLKS) @(negedge i_core_clk);
        check(o_addr_oe, 1'b0);
        @(posedge i_core_clk) i_rst <= 1'b0;
        repeat (9) @(posedge i_core_clk);
        xfer(REQ_FETCH, RESET_FETCH_ADDR, 8'h00, 8'hf0 ^ 8'h5a);
    endtask
    task automatic sc_rw(input logic s);
        slow <= s;
        // not-ready needs time to pass the pin synchroniser
        repeat (4) @(posedge i_core_clk);
        xfer(REQ_WRITE, 20'h12345, 8'ha7, 8'h00);
        xfer(REQ_READ, 20'h0fe3c, 8'h00, 8'h3c ^ 8'h5a);
    endtask
    // irq held high too; nmi must win when both are pending
    task automatic sc_irq(input logic nmi);
        int k;
        @(posedge i_core_clk);
        i_core_if_set <= 1'b1; i_core_boundary <= 1'b1;
        i_nmi <= nmi; i_maskable_irq_in <= 1'b1;
        @(posedge i_core_clk) i_core_if_set <= 1'b0;
        for (k = 0; k < 99 && o_vec_valid !== 1'b1; k++) @(negedge i_core_clk);
        check(o_vec_type, nmi ? NMI_TYPE : 8'h21);
        check(o_core_if, 1'b0);
        @(posedge i_core_clk);
        i_nmi <= 1'b0; i_maskable_irq_in <= 1'b0; i_core_boundary <= 1'b0;
        if (k == 99) begin n_errors++; final_report(); end
        repeat (60) @(posedge i_core_clk);
        i_core_iret <= 1'b1; i_core_iret_if <= 1'b1;
        @(posedge i_core_clk) i_core_iret <= 1'b0;
        repeat (3) @(negedge i_core_clk);
        check(o_core_if, 1'b1);
    endtask
    initial begin
        sc_reset_fetch();
        sc_rw(1'b0);
        sc_rw(1'b1);
        sc_irq(1'b0);
        sc_irq(1'b1);
        final_report();
    end
endmodule
`default_nettype wire
